// >>> src/pslc_fold360.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// fold a signed value into one turn, 0 .. turn-1
// ---------------------------------------------------------------------------
module pslc_fold360
   import pslc_pkg::*;
#(
   parameter int W = WW
) (
   // value in
   input wire logic signed [W-1:0] val,
   // folded value out
   output logic signed [W-1:0] folded
);

   logic signed [W-1:0] rem;

   // negative remainders get one turn added
   always_comb begin
      rem = val % DEG_TURN;
      if (rem < 0) begin
         rem = rem + DEG_TURN;
      end
      folded = rem;
   end

endmodule

// >>> src/pslc_limit_clamp.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// software position limit clamp with apb register file
// ---------------------------------------------------------------------------
module pslc_limit_clamp
   import pslc_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [DW-1:0] pwdata,
   output logic [DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive status
   input wire logic homing_busy,
   input wire logic home_done,
   // position command stream
   input wire pslc_cmd_t cmd_in,
   output pslc_res_t res_out,
   // status outputs
   output logic limit_clamp_warning,
   output logic command_range_alarm,
   output logic limit_detected,
   output logic home_valid,
   output logic irq
);

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   logic [DW-1:0] ctrl_ff;
   logic signed [DW-1:0] upper_travel_limit_ff;
   logic signed [DW-1:0] lower_travel_limit_ff;
   logic signed [DW-1:0] home_offset_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [DW-1:0] prdata_ff;
   logic warn_ff;
   logic alarm_ff;
   logic home_ff;
   logic at_up_ff;
   logic at_lo_ff;
   pslc_res_t res_ff;

   // ------------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------------
   logic setup;
   logic wr_en;
   logic mapped;
   logic [MODE_W-1:0] profile_mode;
   logic [UNIT_W-1:0] position_unit_select;
   logic func_en;

   function automatic logic is_mapped(input logic [AW-1:0] a);
      unique case (a)
         OFS_CTRL, OFS_UPPER, OFS_LOWER, OFS_HOFS, OFS_STATUS,
         OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_LAST_POS: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   assign setup = psel & ~penable;
   assign mapped = is_mapped(paddr);
   assign wr_en = psel & penable & pwrite & mapped & clk_en;
   // zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_ff;

   assign func_en = ctrl_ff[CTRL_EN_BIT];
   assign profile_mode = ctrl_ff[CTRL_MODE_LSB +: MODE_W];
   assign position_unit_select = ctrl_ff[CTRL_UNIT_LSB +: UNIT_W];

   // ------------------------------------------------------------------------
   // position arithmetic
   // ------------------------------------------------------------------------
   // sign-extend a 32-bit value to the working width
   function automatic logic signed [WW-1:0] wide(input logic signed [DW-1:0] v);
      wide = WW'(v);
   endfunction

   // bring a difference of two folded angles back into one turn
   function automatic logic signed [WW-1:0] wrap(input logic signed [WW-1:0] v);
      wrap = (v < 0) ? v + DEG_TURN : v;
   endfunction

   logic signed [WW-1:0] cmd_abs;
   logic signed [WW-1:0] up_w;
   logic signed [WW-1:0] lo_w;
   logic signed [WW-1:0] pos_f;
   logic signed [WW-1:0] up_f;
   logic signed [WW-1:0] lo_f;
   logic is_deg;
   logic pos_mode;
   logic limits_ok;
   logic check_on;
   logic over32;
   logic nxt_over;
   logic nxt_under;
   logic nxt_excess;
   logic signed [WW-1:0] nxt_pos;

   // command plus home offset, wide enough never to wrap
   assign cmd_abs = wide(cmd_in.pos) + wide(home_offset_ff);
   assign up_w = wide(upper_travel_limit_ff) - HOME_POS;
   assign lo_w = wide(lower_travel_limit_ff) - HOME_POS;
   assign is_deg = (position_unit_select == UNIT_DEG);

   // angular view of command and limits
   pslc_fold360 #(
      .W(WW)
   ) u_fold_pos (
      .val(cmd_abs),
      .folded(pos_f)
   );

   pslc_fold360 #(
      .W(WW)
   ) u_fold_up (
      .val(up_w),
      .folded(up_f)
   );

   pslc_fold360 #(
      .W(WW)
   ) u_fold_lo (
      .val(lo_w),
      .folded(lo_f)
   );

   // limit check applies in the four position-type modes only
   always_comb begin
      unique case (profile_mode)
         MODE_CSP, MODE_PP, MODE_PT, MODE_JOG: pos_mode = 1'b1;
         default: pos_mode = 1'b0;
      endcase
   end

   // degree allows a wrapped range, linear units need upper above lower
   assign limits_ok = is_deg ? (up_f != lo_f) : (up_w > lo_w);
   assign check_on = func_en & pos_mode & ~homing_busy & limits_ok;
   assign over32 = (cmd_abs > POS32_MAX) | (cmd_abs < POS32_MIN);

   // clamp decision
   always_comb begin
      logic signed [WW-1:0] d_up;
      logic signed [WW-1:0] d_lo;
      logic in_range;
      d_up = wrap(pos_f - up_f);
      d_lo = wrap(lo_f - pos_f);
      in_range = 1'b1;
      nxt_over = 1'b0;
      nxt_under = 1'b0;
      nxt_excess = 1'b0;
      nxt_pos = cmd_abs;
      if (check_on && is_deg) begin
         // a wrapped range runs from lower through 0 to upper
         if (lo_f < up_f) begin
            in_range = (pos_f >= lo_f) && (pos_f <= up_f);
         end else begin
            in_range = (pos_f >= lo_f) || (pos_f <= up_f);
         end
         // leave by the shorter way back into the range
         if (!in_range) begin
            if (d_up <= d_lo) begin
               nxt_over = 1'b1;
               nxt_pos = cmd_abs - d_up;
            end else begin
               nxt_under = 1'b1;
               nxt_pos = cmd_abs + d_lo;
            end
         end
      end else if (check_on) begin
         if (cmd_abs > up_w) begin
            nxt_over = 1'b1;
            nxt_pos = up_w;
            nxt_excess = (cmd_abs - up_w) > SPAN30_MAX;
         end else if (cmd_abs < lo_w) begin
            nxt_under = 1'b1;
            nxt_pos = lo_w;
            nxt_excess = (cmd_abs - lo_w) < SPAN30_MIN;
         end
         // a command inside the range passes even after a limit was hit
      end
   end

   logic cmd_take;
   logic cmd_err;
   logic nxt_clamp;

   assign cmd_take = cmd_in.valid & pos_mode & ~homing_busy;
   assign cmd_err = cmd_take & (over32 | nxt_excess);
   assign nxt_clamp = nxt_over | nxt_under;

   // ------------------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------------------
   // control: enable, mode, unit; alarm clear is a one-shot bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_en && paddr == OFS_CTRL) begin
         ctrl_ff <= pwdata;
         ctrl_ff[CTRL_ALM_CLR_BIT] <= 1'b0;
      end
   end

   // limits and home offset; changing them while moving is the
   // controller's business, the block takes them as they come
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_travel_limit_ff <= LIMIT_RST;
         lower_travel_limit_ff <= LIMIT_RST;
         home_offset_ff <= LIMIT_RST;
      end else if (wr_en) begin
         if (paddr == OFS_UPPER) begin
            upper_travel_limit_ff <= pwdata;
         end
         if (paddr == OFS_LOWER) begin
            lower_travel_limit_ff <= pwdata;
         end
         if (paddr == OFS_HOFS) begin
            home_offset_ff <= pwdata;
         end
      end
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= MASK_RST;
      end else if (wr_en && paddr == OFS_IRQ_MASK) begin
         irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
   end

   // ------------------------------------------------------------------------
   // command path
   // ------------------------------------------------------------------------
   // limited command goes out one cycle after it is taken; a
   // command in error is dropped so the motor never sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_ff <= '0;
         at_up_ff <= 1'b0;
         at_lo_ff <= 1'b0;
      end else if (clk_en) begin
         res_ff.valid <= cmd_take & ~cmd_err;
         if (cmd_take && !cmd_err) begin
            res_ff.pos <= nxt_pos[DW-1:0];
            res_ff.clamped <= nxt_clamp;
            at_up_ff <= nxt_over;
            at_lo_ff <= nxt_under;
         end else if (!check_on) begin
            res_ff.clamped <= 1'b0;
            at_up_ff <= 1'b0;
            at_lo_ff <= 1'b0;
         end
      end
   end

   // warning follows the clamp of the latest command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_ff <= 1'b0;
      end else if (clk_en) begin
         if (!check_on) begin
            warn_ff <= 1'b0;
         end else if (cmd_take && !cmd_err) begin
            warn_ff <= nxt_clamp;
         end
      end
   end

   // alarm latches until software clears it; a new error wins the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_ff <= 1'b0;
      end else if (clk_en) begin
         if (cmd_err) begin
            alarm_ff <= 1'b1;
         end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_ALM_CLR_BIT]) begin
            alarm_ff <= 1'b0;
         end
      end
   end

   // home position: set by a finished homing run, erased by the alarm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         home_ff <= 1'b0;
      end else if (clk_en) begin
         if (cmd_err) begin
            home_ff <= 1'b0;
         end else if (home_done) begin
            home_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------------------
   logic [IRQ_W-1:0] irq_set;

   assign irq_set[IRQ_WARN_BIT] = cmd_take & ~cmd_err & nxt_clamp & ~warn_ff;
   assign irq_set[IRQ_ALARM_BIT] = cmd_err;

   // sticky events, write one to clear; a set in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= '0;
      end else if (clk_en) begin
         if (wr_en && paddr == OFS_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
         end
      end
   end

   // ------------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------------
   logic [DW-1:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[ST_HOME_BIT] = home_ff;
      status_word[ST_WARN_BIT] = warn_ff;
      status_word[ST_ALARM_BIT] = alarm_ff;
      status_word[ST_ACTIVE_BIT] = check_on;
      status_word[ST_AT_UP_BIT] = at_up_ff;
      status_word[ST_AT_LO_BIT] = at_lo_ff;
   end

   // read data is sampled at setup so it comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (clk_en && setup && !pwrite) begin
         unique case (paddr)
            OFS_CTRL: prdata_ff <= ctrl_ff;
            OFS_UPPER: prdata_ff <= upper_travel_limit_ff;
            OFS_LOWER: prdata_ff <= lower_travel_limit_ff;
            OFS_HOFS: prdata_ff <= home_offset_ff;
            OFS_STATUS: prdata_ff <= status_word;
            OFS_IRQ_STAT: prdata_ff <= DW'(irq_stat_ff);
            OFS_IRQ_MASK: prdata_ff <= DW'(irq_mask_ff);
            OFS_LAST_POS: prdata_ff <= res_ff.pos;
            default: prdata_ff <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------------
   assign res_out = res_ff;
   assign limit_clamp_warning = warn_ff;
   assign command_range_alarm = alarm_ff;
   // the controller stops a csp command stream on this flag
   assign limit_detected = at_up_ff | at_lo_ff;
   assign home_valid = home_ff;
   assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule

// >>> src/pslc_pkg.sv
// ---------------------------------------------------------------------------
// Summary of operation
// - a command beyond a travel limit is replaced by that limit value
// - both limits are measured from machine home, position address zero
// - limits compare against command plus home offset
// - limit_clamp_warning stands while the latest command is being clamped
// - commands moving back from a reached limit pass unchanged
// - command_range_alarm when the command leaves the signed 32-bit range
// - command_range_alarm when a limit is overrun by more than a 30-bit span
// - command_range_alarm erases the home position; homing must be redone
// - the check runs only in csp, profile position, point table and jog
// - the check is suspended while homing is in progress
// - after reset the travel-limit function is disabled
// - limits and positions use the unit chosen by position_unit_select
// - linear units need upper above lower; degree needs the two to differ
// - degree limits fold into 0 to 359.999 degrees, modulo 360
// ---------------------------------------------------------------------------
package pslc_pkg;

   // widths
   localparam int DW = 32;
   localparam int WW = 34;
   localparam int AW = 8;
   localparam int MODE_W = 3;
   localparam int UNIT_W = 2;
   localparam int IRQ_W = 2;

   // register byte offsets
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_UPPER = 8'h04;
   localparam logic [AW-1:0] OFS_LOWER = 8'h08;
   localparam logic [AW-1:0] OFS_HOFS = 8'h0C;
   localparam logic [AW-1:0] OFS_STATUS = 8'h10;
   localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [AW-1:0] OFS_LAST_POS = 8'h1C;

   // control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_ALM_CLR_BIT = 1;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_UNIT_LSB = 8;

   // status fields
   localparam int ST_HOME_BIT = 0;
   localparam int ST_WARN_BIT = 1;
   localparam int ST_ALARM_BIT = 2;
   localparam int ST_ACTIVE_BIT = 3;
   localparam int ST_AT_UP_BIT = 4;
   localparam int ST_AT_LO_BIT = 5;

   // interrupt bits
   localparam int IRQ_WARN_BIT = 0;
   localparam int IRQ_ALARM_BIT = 1;

   // drive modes
   localparam logic [MODE_W-1:0] MODE_CSP = 3'h0;
   localparam logic [MODE_W-1:0] MODE_PP = 3'h1;
   localparam logic [MODE_W-1:0] MODE_PT = 3'h2;
   localparam logic [MODE_W-1:0] MODE_JOG = 3'h3;
   localparam logic [MODE_W-1:0] MODE_HOMING = 3'h4;

   // position units
   localparam logic [UNIT_W-1:0] UNIT_MM = 2'h0;
   localparam logic [UNIT_W-1:0] UNIT_INCH = 2'h1;
   localparam logic [UNIT_W-1:0] UNIT_DEG = 2'h2;
   localparam logic [UNIT_W-1:0] UNIT_PULSE = 2'h3;

   // arithmetic bounds
   localparam logic signed [WW-1:0] POS32_MAX = 34'sh0_7FFF_FFFF;
   localparam logic signed [WW-1:0] POS32_MIN = 34'sh3_8000_0000;
   localparam logic signed [WW-1:0] SPAN30_MAX = 34'sh0_1FFF_FFFF;
   localparam logic signed [WW-1:0] SPAN30_MIN = 34'sh3_E000_0000;
   localparam logic signed [WW-1:0] DEG_TURN = 34'sh0_0005_7E40;
   localparam logic signed [WW-1:0] HOME_POS = 34'sh0_0000_0000;

   // reset values
   localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
   localparam logic [DW-1:0] LIMIT_RST = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

   // command in, limited command out
   typedef struct packed {
      logic valid;
      logic signed [DW-1:0] pos;
   } pslc_cmd_t;

   typedef struct packed {
      logic valid;
      logic clamped;
      logic signed [DW-1:0] pos;
   } pslc_res_t;

endpackage

// >>> test/pslc_cmd_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// motion controller issuing position commands
// ---------------------------------------------------------------------------
module pslc_cmd_model
   import pslc_pkg::*;
(
   // clock
   input wire logic pclk,
   // command stream toward the drive
   output pslc_cmd_t cmd_out,
   // limit feedback from the drive
   input wire logic limit_detected
);
   // quiet at start
   initial cmd_out = '0;

   // one strobe; idle pos shows the inverse
   task automatic issue(input logic signed [DW-1:0] p);
      @(posedge pclk);
      cmd_out <= '{valid: 1'b1, pos: p};
      @(posedge pclk);
      cmd_out <= '{valid: 1'b0, pos: ~p};
   endtask

   // csp ramp that stops advancing once the drive reports a limit
   task automatic ramp(input logic signed [DW-1:0] p0, input logic signed [DW-1:0] step,
         input int max_n, output int n);
      for (n = 0; n < max_n; n++) begin
         issue(p0 + step * n);
         #1;
         if (limit_detected === 1'b1) begin
            break;
         end
      end
   endtask
endmodule

// >>> test/pslc_limit_clamp_props.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// port-level checks of the limit clamp
// ---------------------------------------------------------------------------
module pslc_limit_clamp_props
   import pslc_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [DW-1:0] pwdata,
   input wire logic [DW-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // drive status and commands
   input wire logic homing_busy,
   input wire logic home_done,
   input wire pslc_cmd_t cmd_in,
   input wire pslc_res_t res_out,
   // flags
   input wire logic limit_clamp_warning,
   input wire logic command_range_alarm,
   input wire logic limit_detected,
   input wire logic home_valid,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // a strobe the enable lets through, and a cycle with nothing offered
   sequence s_cmd_seen;
      cmd_in.valid && clk_en;
   endsequence
   sequence s_idle;
      clk_en && !cmd_in.valid;
   endsequence

   a_homing_blocks:
      assert property (s_cmd_seen ##0 homing_busy |=> !res_out.valid)
      else $error("result produced during homing");
   a_result_cause:
      assert property (res_out.valid && $past(clk_en) |-> $past(cmd_in.valid) && !$past(homing_busy))
      else $error("result without a taken command");
   a_warn_clamp:
      assert property (res_out.valid |-> limit_clamp_warning == res_out.clamped)
      else $error("warning disagrees with clamp");
   a_detect_clamp:
      assert property (res_out.valid |-> limit_detected == res_out.clamped)
      else $error("limit flag disagrees with clamp");
   a_result_holds:
      assert property (s_idle |=> $stable(res_out.pos) && !$rose(limit_clamp_warning))
      else $error("result moved without a command");
   a_single_pulse:
      assert property (s_idle ##0 res_out.valid |=> !res_out.valid)
      else $error("result strobe longer than one cycle");
   a_error_erases:
      assert property ($rose(command_range_alarm) |-> !home_valid && !res_out.valid)
      else $error("alarm left home or gave a result");
   a_alarm_sticky:
      assert property (command_range_alarm && !(psel && penable && pwrite) |=> command_range_alarm)
      else $error("alarm dropped without a write");
   a_home_set:
      assert property (home_done && clk_en && !cmd_in.valid |=> home_valid)
      else $error("home not established");
endmodule

// >>> test/test_software_position_limit_clamp.sv
`timescale 1ns/1ps
module test_software_position_limit_clamp
   import pslc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [AW-1:0] paddr = 8'h00;
   logic [DW-1:0] pwdata = 32'h0;
   logic [DW-1:0] prdata;
   logic pready;
   logic pslverr;
   logic homing_busy = 1'b0;
   logic home_done = 1'b0;
   pslc_cmd_t cmd_in;
   pslc_res_t res_out;
   logic limit_clamp_warning;
   logic command_range_alarm;
   logic limit_detected;
   logic home_valid;
   logic irq;
   int mismatches = 0;
   int samples_checked = 0;

   // 10 MHz clock
   always #50 pclk = ~pclk;

   pslc_limit_clamp uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .homing_busy(homing_busy), .home_done(home_done),
      .cmd_in(cmd_in), .res_out(res_out), .limit_clamp_warning(limit_clamp_warning),
      .command_range_alarm(command_range_alarm), .limit_detected(limit_detected),
      .home_valid(home_valid), .irq(irq));
   pslc_cmd_model ctl (.pclk(pclk), .cmd_out(cmd_in), .limit_detected(limit_detected));

   // ------------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------------
   task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; the request stands until pready is seen high
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
         output logic [DW-1:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      logic [DW-1:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input string what, input logic [AW-1:0] a, input logic [DW-1:0] exp);
      logic [DW-1:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check(what, q, exp);
   endtask

   // limits are written in homing mode so no command sees a half-changed set
   task automatic cfg(input logic [MODE_W-1:0] m, input logic [UNIT_W-1:0] u,
         input logic [DW-1:0] up, input logic [DW-1:0] lo, input logic [DW-1:0] ofs);
      wr(OFS_CTRL, {22'h0, u, 1'b0, MODE_HOMING, 4'h1});
      wr(OFS_UPPER, up);
      wr(OFS_LOWER, lo);
      wr(OFS_HOFS, ofs);
      wr(OFS_CTRL, {22'h0, u, 1'b0, m, 4'h1});
   endtask

   task automatic send(input logic signed [DW-1:0] p, input logic v,
         input logic signed [DW-1:0] q, input logic c);
      ctl.issue(p);
      #1;
      check("result valid", res_out.valid, v);
      if (v) begin
         check("result pos", res_out.pos, q);
         check("clamped", res_out.clamped, c);
         check("warning", limit_clamp_warning, c);
         check("detected", limit_detected, c);
      end
   endtask

   task automatic clear_alarm();
      wr(OFS_CTRL, {22'h0, UNIT_MM, 1'b0, MODE_CSP, 4'h3});
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------------
   task automatic t_reset();
      logic [DW-1:0] q;
      logic e;
      rd("ctrl", OFS_CTRL, CTRL_RST);
      rd("upper", OFS_UPPER, LIMIT_RST);
      rd("lower", OFS_LOWER, LIMIT_RST);
      rd("status", OFS_STATUS, 32'h0);
      rd("mask", OFS_IRQ_MASK, {30'h0, MASK_RST});
      send(5000, 1'b1, 5000, 1'b0);
      apb(1'b0, 8'h20, 32'h0, q, e);
      check("unmapped data", q, 32'h0);
      check("unmapped err", e, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_clamp();
      int n;
      cfg(MODE_CSP, UNIT_MM, 1000, -1000, 0);
      send(1500, 1'b1, 1000, 1'b1);
      send(-2000, 1'b1, -1000, 1'b1);
      send(1000, 1'b1, 1000, 1'b0);
      send(500, 1'b1, 500, 1'b0);
      ctl.ramp(900, 40, 10, n);
      check("ramp steps", n, 3);
      check("ramp pos", res_out.pos, 1000);
      wr(OFS_HOFS, 200);
      send(900, 1'b1, 1000, 1'b1);
      send(700, 1'b1, 900, 1'b0);
      for (int i = 0; i < 4; i++) begin
         if (i != 2) begin
            cfg(MODE_CSP, i[1:0], 1000, -1000, 0);
            send(-1500, 1'b1, -1000, 1'b1);
         end
      end
      cfg(MODE_CSP, UNIT_MM, -5, 5, 0);
      send(100, 1'b1, 100, 1'b0);
      cfg(MODE_CSP, UNIT_DEG, 675000, 90000, 0);
      send(330000, 1'b1, 315000, 1'b1);
      cfg(MODE_CSP, UNIT_DEG, 90000, 315000, 0);
      send(180000, 1'b1, 90000, 1'b1);
      $display("test clamp done");
   endtask

   task automatic t_modes();
      cfg(MODE_CSP, UNIT_MM, 1000, -1000, 0);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CTRL, {22'h0, UNIT_MM, 1'b0, i[2:0], 4'h1});
         send(2000, i < 4, 1000, 1'b1);
      end
      wr(OFS_CTRL, {22'h0, UNIT_MM, 1'b0, MODE_CSP, 4'h1});
      @(posedge pclk);
      homing_busy <= 1'b1;
      send(2000, 1'b0, 0, 1'b0);
      @(posedge pclk);
      homing_busy <= 1'b0;
      clk_en <= 1'b0;
      send(2000, 1'b0, 0, 1'b0);
      @(posedge pclk);
      clk_en <= 1'b1;
      $display("test modes done");
   endtask

   task automatic t_error();
      wr(OFS_IRQ_STAT, 32'h3);
      wr(OFS_IRQ_MASK, 32'h3);
      cfg(MODE_CSP, UNIT_MM, 1000, -1000, 32'h7FFF_FFFF);
      @(posedge pclk);
      home_done <= 1'b1;
      @(posedge pclk);
      home_done <= 1'b0;
      #1;
      check("home set", home_valid, 1'b1);
      send(10, 1'b0, 0, 1'b0);
      check("alarm", command_range_alarm, 1'b1);
      check("home erased", home_valid, 1'b0);
      check("irq on", irq, 1'b1);
      rd("irq stat", OFS_IRQ_STAT, 32'h2);
      wr(OFS_IRQ_STAT, 32'h2);
      clear_alarm();
      #1;
      check("irq off", irq, 1'b0);
      check("alarm off", command_range_alarm, 1'b0);
      wr(OFS_HOFS, 0);
      send(536871911, 1'b1, 1000, 1'b1);
      send(536871912, 1'b0, 0, 1'b0);
      check("upper overrun", command_range_alarm, 1'b1);
      clear_alarm();
      send(-536871912, 1'b1, -1000, 1'b1);
      send(-536871913, 1'b0, 0, 1'b0);
      check("lower overrun", command_range_alarm, 1'b1);
      clear_alarm();
      wr(OFS_IRQ_STAT, 32'h3);
      wr(OFS_IRQ_MASK, 32'h1);
      send(0, 1'b1, 0, 1'b0);
      send(1500, 1'b1, 1000, 1'b1);
      check("warn irq", irq, 1'b1);
      wr(OFS_IRQ_MASK, 32'h0);
      #1;
      check("masked irq", irq, 1'b0);
      rd("status", OFS_STATUS, 32'h0000_001A);
      rd("last pos", OFS_LAST_POS, 32'h0000_03E8);
      $display("test error done");
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_clamp();
      t_modes();
      t_error();
      tally_and_finish();
   end

   // watchdog, far past the test length
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      tally_and_finish();
   end
endmodule

bind pslc_limit_clamp pslc_limit_clamp_props u_props (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .homing_busy(homing_busy), .home_done(home_done), .cmd_in(cmd_in), .res_out(res_out),
   .limit_clamp_warning(limit_clamp_warning), .command_range_alarm(command_range_alarm),
   .limit_detected(limit_detected), .home_valid(home_valid), .irq(irq));
